// ==== core/vpwed_sym.sv ====
// package of constants and the symbol width timer
package vpwed_pkg;
  localparam int CLK_MHZ = 20;
  localparam int WID = 13;
  localparam int TV1_MIN_US = 35;
  localparam int TV1_MAX_US = 95;
  localparam int TV2_MIN_US = 96;
  localparam int TV2_MAX_US = 163;
  localparam int TV3_MAX_US = 239;
  localparam int TV4_MIN_US = 239;
  localparam int IFR_WAIT_US = 135;
  localparam int PD_PULSE_US = 7;
  localparam int ECHO_US = 10;
  localparam logic [WID-1:0] TV1_MIN_CYC = WID'(TV1_MIN_US * CLK_MHZ);
  localparam logic [WID-1:0] TV1_MAX_CYC = WID'(TV1_MAX_US * CLK_MHZ);
  localparam logic [WID-1:0] TV2_MIN_CYC = WID'(TV2_MIN_US * CLK_MHZ);
  localparam logic [WID-1:0] TV2_MAX_CYC = WID'(TV2_MAX_US * CLK_MHZ);
  localparam int TV3_MAX_DEF = TV3_MAX_US * CLK_MHZ;
  localparam int TV4_MIN_DEF = TV4_MIN_US * CLK_MHZ;
  localparam logic [WID-1:0] IFR_WAIT_CYC = WID'(IFR_WAIT_US * CLK_MHZ);
  localparam logic [WID-1:0] PD_PULSE_CYC = WID'(PD_PULSE_US * CLK_MHZ);
  localparam logic [WID-1:0] ECHO_CYC = WID'(ECHO_US * CLK_MHZ);
  localparam logic [2:0] BIT_CNT_RST = 3'h0;
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_READY = 2'b01,
    ST_FRAME = 2'b10,
    ST_GAP0 = 2'b11
  } vpwed_state_e;
endpackage : vpwed_pkg

`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module vpwed_sym #(
  parameter int MARK_CYC = 3261,
  parameter int IDLE_CYC = 4780
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_act,
  output logic edge_ff,
  output logic was_act_ff,
  output logic [vpwed_pkg::WID-1:0] width_ff,
  output logic mark_ff,
  output logic idle_ff
);
  import vpwed_pkg::*;
  initial if (IDLE_CYC >= (1 << WID) || MARK_CYC >= IDLE_CYC || MARK_CYC < 2)
    $error("vpwed_sym: thresholds out of range");
  logic prev_ff, nxt_prev, nxt_edge, nxt_was_act, nxt_mark, nxt_idle;
  logic [WID-1:0] cnt_ff, nxt_cnt, nxt_width;
  always_comb
  begin
    nxt_prev = line_act;
    nxt_edge = line_act != prev_ff;
    nxt_was_act = was_act_ff;
    nxt_width = width_ff;
    // saturate so a stuck line never wraps into a fake short symbol
    nxt_cnt = (cnt_ff == {WID{1'b1}}) ? cnt_ff : cnt_ff + 1'b1;
    if (nxt_edge)
    begin
      nxt_was_act = prev_ff;
      nxt_width = cnt_ff;
      nxt_cnt = {{(WID-1){1'b0}}, 1'b1};
    end
    nxt_mark = !line_act && !nxt_edge && cnt_ff == WID'(MARK_CYC);
    // level, so an abort on a bus that is already quiet still finds idle
    nxt_idle = !line_act && !nxt_edge && cnt_ff >= WID'(IDLE_CYC);
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_ff <= 1'b0;
      edge_ff <= 1'b0;
      was_act_ff <= 1'b0;
      width_ff <= '0;
      cnt_ff <= '0;
      mark_ff <= 1'b0;
      idle_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= nxt_prev;
      edge_ff <= nxt_edge;
      was_act_ff <= nxt_was_act;
      width_ff <= nxt_width;
      cnt_ff <= nxt_cnt;
      mark_ff <= nxt_mark;
      idle_ff <= nxt_idle;
    end
  end
endmodule : vpwed_sym

// ==== core/vpwed_top.sv ====
// error detection, abort, wait-for-idle and loopback for a byte-level vpw interface
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE_01: test input high puts the device into loopback of its own transmit.
// RULE_02: loopback ignores the bus input, feeds transmit back, pin still toggles.
// RULE_03: a general or check-byte error aborts the message and waits for idle.
// RULE_04: noise shorter than minimum short symbol sets the error, even while waiting.
// RULE_05: a non short, long or break symbol mid-message sets the error.
// RULE_06: a received bit count not a multiple of eight sets the error.
// RULE_07: host starting over 96 us after bus quiet sets the error.
// RULE_08: bad start, end-of-data, end-of-frame or normalization widths set the error.
// RULE_09: start of frame sooner than TV4 after a type 0 message sets the error.
// RULE_10: missing transfer strobe or short-form last byte while sending sets the error.
// RULE_11: requested in-frame response without strobe within 135 us sets the error.
// RULE_12: single-byte type 1 or 2 response without long strobe sets the error.
// RULE_13: register exchange during a data byte sets the error, no wait-for-idle.
// RULE_14: data byte starting during a register exchange while sending sets the error.
// RULE_15: a driven transition not echoed on the receive input sets the error.
// RULE_16: any failure during the test sequence sets the error.
// RULE_17: a low pulse under 7 us during power-down sets the error.
// RULE_18: start directly followed by end-of-data sets only the check-byte error.
// RULE_19: waiting for idle discards all but noise; entered on reset, skip, errors.
// RULE_20: after type 1 to 3 messages, later symbols are ignored silently until idle.
// RULE_21: bad body check byte sets the check-byte error and drops any response.
// RULE_22: bad response check byte on an otherwise good type 3 frame sets it too.
// RULE_23: a break stops transmission and enters wait-for-idle; here a break in ready or frame state only enters wait-for-idle and abort_msg stays low.
// RULE_24: host enables loopback only after the bus quiet indicator is low.
// RULE_25: host resets and reprograms the divider after repeated errors.
// RULE_26: both error flags hold until the host reads status, then clear.
module vpwed_top
  import vpwed_pkg::*;
#(
  parameter int TV3_MAX_CYC = vpwed_pkg::TV3_MAX_DEF,
  parameter int TV4_CYC = vpwed_pkg::TV4_MIN_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_receive_input_n,
  input wire logic test_mode_in,
  input wire logic tx_drive,
  input wire logic transmitting,
  input wire logic host_tx_start,
  input wire logic xfer_start,
  input wire logic xfer_strobe,
  input wire logic xfer_long,
  input wire logic xfer_last,
  input wire logic data_xfer_active,
  input wire logic ifr_request,
  input wire logic [1:0] msg_type,
  input wire logic body_crc_done,
  input wire logic body_crc_bad,
  input wire logic ifr_crc_bad,
  input wire logic reg_xchg_start,
  input wire logic reg_xchg_active,
  input wire logic reg_xchg_done,
  input wire logic test_seq_active,
  input wire logic test_fail,
  input wire logic sleep_request_bit,
  input wire logic skip_to_next_bit,
  output logic bus_transmit_output,
  output logic rx_seen_n,
  output logic gen_err_flag,
  output logic crc_err_flag,
  output logic wait_idle,
  output logic abort_msg,
  output logic bus_quiet
);
  import vpwed_pkg::*;
  initial if (TV4_CYC >= (1 << WID) || TV3_MAX_CYC <= int'(TV2_MAX_CYC) || TV3_MAX_CYC > TV4_CYC)
    $error("vpwed_top: timing parameters out of range");

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and loopback path
  logic rx_meta_ff, rx_sync_ff, test_meta_ff, test_sync_ff, tx_ff, rx_ff;
  logic nxt_rx;
  always_comb
  begin
    // loopback replaces the bus input with our own drive
    nxt_rx = test_sync_ff ? !tx_ff : rx_sync_ff; // RULE_01 RULE_02
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      test_meta_ff <= 1'b0;
      test_sync_ff <= 1'b0;
      tx_ff <= 1'b0;
      rx_ff <= 1'b1;
    end
    else
    begin
      rx_meta_ff <= bus_receive_input_n;
      rx_sync_ff <= rx_meta_ff;
      test_meta_ff <= test_mode_in;
      test_sync_ff <= test_meta_ff;
      tx_ff <= tx_drive; // RULE_02
      rx_ff <= nxt_rx;
    end
  end
  assign bus_transmit_output = tx_ff;
  assign rx_seen_n = rx_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // symbol timing
  logic sym_edge, sym_act, sym_mark, sym_idle;
  logic [WID-1:0] sym_w;
  vpwed_sym #(
    .MARK_CYC(int'(TV2_MAX_CYC) + 1),
    .IDLE_CYC(TV4_CYC)
  ) u_sym (
    .clk(clk),
    .rst_n(rst_n),
    .line_act(!rx_ff),
    .edge_ff(sym_edge),
    .was_act_ff(sym_act),
    .width_ff(sym_w),
    .mark_ff(sym_mark),
    .idle_ff(sym_idle)
  );
  logic is_noise, is_short, is_long, is_sof, is_break;
  always_comb
  begin
    is_noise = sym_w < TV1_MIN_CYC;
    is_short = !is_noise && sym_w <= TV1_MAX_CYC;
    is_long = sym_w >= TV2_MIN_CYC && sym_w <= TV2_MAX_CYC;
    is_sof = sym_w > TV2_MAX_CYC && sym_w <= WID'(TV3_MAX_CYC);
    is_break = sym_w > WID'(TV3_MAX_CYC);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame state, host checks and flags
  vpwed_state_e state_ff, nxt_state;
  logic [2:0] bits_ff, nxt_bits;
  logic bits_any_ff, nxt_bits_any;
  logic [WID-1:0] quiet_cnt_ff, nxt_quiet_cnt, ifr_cnt_ff, nxt_ifr_cnt, echo_cnt_ff, nxt_echo_cnt;
  logic ifr_first_ff, nxt_ifr_first;
  logic gen_ff, nxt_gen, crc_ff, nxt_crc, abort_ff, nxt_abort, wait_ff, nxt_wait, quiet_ff, nxt_quiet;
  logic err_hard, err_soft, crc_set;
  always_comb
  begin
    nxt_state = state_ff;
    nxt_bits = bits_ff;
    nxt_bits_any = bits_any_ff;
    err_hard = 1'b0;
    err_soft = 1'b0;
    crc_set = 1'b0;
    if (sleep_request_bit)
    begin
      // clock is still running here, so the filter measures what would wake us
      if (sym_edge && sym_act && sym_w < PD_PULSE_CYC)
        err_hard = 1'b1; // RULE_17
    end
    else
    begin
      unique case (state_ff)
        ST_WAIT:
        begin
          if (sym_edge && is_noise)
            err_hard = 1'b1; // RULE_04
          if (sym_idle)
            nxt_state = ST_READY; // RULE_19 RULE_20
        end
        ST_READY:
        begin
          if (sym_edge && is_noise)
            err_hard = 1'b1; // RULE_04
          else if (sym_edge && sym_act && is_break)
            nxt_state = ST_WAIT; // RULE_23
          else if (sym_edge && sym_act && is_sof)
          begin
            nxt_state = ST_FRAME;
            nxt_bits = BIT_CNT_RST;
            nxt_bits_any = 1'b0;
          end
          else if (sym_edge && sym_act)
            err_hard = 1'b1; // RULE_08
        end
        ST_FRAME:
        begin
          if (sym_edge && is_noise)
            err_hard = 1'b1; // RULE_04
          else if (sym_edge && sym_act && is_break)
            nxt_state = ST_WAIT; // RULE_23
          else if (sym_edge && (is_short || is_long))
          begin
            nxt_bits = bits_ff + 3'h1;
            nxt_bits_any = 1'b1;
          end
          else if (sym_edge)
            err_hard = 1'b1; // RULE_05 RULE_08
          else if (sym_mark)
          begin
            if (!bits_any_ff)
              crc_set = 1'b1; // RULE_18
            else if (bits_ff != BIT_CNT_RST)
              err_hard = 1'b1; // RULE_06
            else if (msg_type == 2'h0)
              nxt_state = ST_GAP0;
            else
              nxt_state = ST_WAIT; // RULE_19 RULE_20
          end
        end
        ST_GAP0:
        begin
          if (sym_edge && sym_act)
            err_hard = 1'b1; // RULE_04 RULE_09
          else if (sym_idle)
            nxt_state = ST_READY;
        end
      endcase
    end
    if (host_tx_start && quiet_cnt_ff > TV2_MIN_CYC)
      err_hard = 1'b1; // RULE_07
    if (transmitting && xfer_start && (!xfer_strobe || (xfer_last && !xfer_long)))
      err_hard = 1'b1; // RULE_10
    if (ifr_cnt_ff == WID'(1) && !xfer_strobe)
      err_hard = 1'b1; // RULE_11
    if (ifr_first_ff && xfer_start && (msg_type == 2'h1 || msg_type == 2'h2) && !xfer_long)
      err_hard = 1'b1; // RULE_12
    if (reg_xchg_start && data_xfer_active)
      err_soft = 1'b1; // RULE_13
    if (transmitting && xfer_start && reg_xchg_active)
      err_hard = 1'b1; // RULE_14
    if (echo_cnt_ff == WID'(1) && rx_ff == tx_ff)
      err_hard = 1'b1; // RULE_15
    if (test_seq_active && test_fail)
      err_hard = 1'b1; // RULE_16
    if (body_crc_bad || (ifr_crc_bad && msg_type == 2'h3))
      crc_set = 1'b1; // RULE_21 RULE_22
    nxt_abort = err_hard || crc_set; // RULE_03
    if (nxt_abort || skip_to_next_bit)
      nxt_state = ST_WAIT; // RULE_03 RULE_19
    // set wins over the read that clears
    nxt_gen = err_hard || err_soft || (gen_ff && !reg_xchg_done); // RULE_26
    nxt_crc = crc_set || (crc_ff && !reg_xchg_done); // RULE_26
  end

  always_comb
  begin
    nxt_quiet_cnt = '0;
    if (state_ff == ST_READY)
      nxt_quiet_cnt = (quiet_cnt_ff == {WID{1'b1}}) ? quiet_cnt_ff : quiet_cnt_ff + 1'b1;
    nxt_ifr_cnt = (ifr_cnt_ff == '0 || xfer_strobe) ? '0 : ifr_cnt_ff - 1'b1; // RULE_11
    nxt_ifr_first = ifr_first_ff && !xfer_start;
    // a bad body check byte drops the response timer as well
    if (body_crc_done && !body_crc_bad && ifr_request)
    begin
      nxt_ifr_cnt = IFR_WAIT_CYC;
      nxt_ifr_first = 1'b1;
    end
    if (body_crc_bad || nxt_abort || skip_to_next_bit)
    begin
      nxt_ifr_cnt = '0; // RULE_21
      nxt_ifr_first = 1'b0;
    end
    nxt_echo_cnt = (echo_cnt_ff == '0 || rx_ff != tx_ff) ? '0 : echo_cnt_ff - 1'b1;
    if (tx_drive != tx_ff)
      nxt_echo_cnt = ECHO_CYC; // RULE_15
    nxt_wait = (nxt_state == ST_WAIT); // RULE_19
    nxt_quiet = (nxt_state == ST_READY);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_WAIT; // RULE_19
      bits_ff <= BIT_CNT_RST;
      bits_any_ff <= 1'b0;
      quiet_cnt_ff <= '0;
      ifr_cnt_ff <= '0;
      ifr_first_ff <= 1'b0;
      echo_cnt_ff <= '0;
      gen_ff <= 1'b0;
      crc_ff <= 1'b0;
      abort_ff <= 1'b0;
      wait_ff <= 1'b1;
      quiet_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      bits_ff <= nxt_bits;
      bits_any_ff <= nxt_bits_any;
      quiet_cnt_ff <= nxt_quiet_cnt;
      ifr_cnt_ff <= nxt_ifr_cnt;
      ifr_first_ff <= nxt_ifr_first;
      echo_cnt_ff <= nxt_echo_cnt;
      gen_ff <= nxt_gen;
      crc_ff <= nxt_crc;
      abort_ff <= nxt_abort;
      wait_ff <= nxt_wait;
      quiet_ff <= nxt_quiet;
    end
  end
  assign gen_err_flag = gen_ff;
  assign crc_err_flag = crc_ff;
  assign abort_msg = abort_ff;
  assign wait_idle = wait_ff;
  assign bus_quiet = quiet_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_frame_end;
    state_ff == ST_FRAME && !sleep_request_bit && sym_mark && !sym_edge;
  endsequence
  sequence s_status_read;
    reg_xchg_done && !err_hard && !err_soft;
  endsequence

  chk_loop_path: assert property (test_sync_ff ##1 test_sync_ff |=> rx_seen_n == !$past(bus_transmit_output)) // RULE_01
    else $error("loopback does not return own drive");
  chk_abort_wait: assert property (abort_msg |-> wait_idle && (gen_err_flag || crc_err_flag)) // RULE_03
    else $error("abort without error or wait state");
  chk_noise_flag: assert property (sym_edge && is_noise && !sleep_request_bit |=> gen_err_flag && wait_idle) // RULE_04
    else $error("noise not flagged");
  chk_odd_bits: assert property (s_frame_end ##0 (bits_any_ff && bits_ff != BIT_CNT_RST) |=> gen_err_flag) // RULE_06
    else $error("incomplete byte not flagged");
  chk_zero_len: assert property (s_frame_end ##0 !bits_any_ff |=> crc_err_flag ##0 wait_idle) // RULE_18
    else $error("zero length not flagged");
  chk_late_start: assert property (host_tx_start && quiet_cnt_ff > TV2_MIN_CYC |=> gen_err_flag && abort_msg) // RULE_07
    else $error("late start not flagged");
  chk_ifr_timeout: assert property (ifr_cnt_ff == WID'(1) && !xfer_strobe |=> gen_err_flag) // RULE_11
    else $error("response timeout not flagged");
  chk_soft_err: assert property (reg_xchg_start && data_xfer_active && !err_hard && !crc_set
    |=> gen_err_flag && !abort_msg) // RULE_13
    else $error("register exchange error handled wrongly");
  chk_echo_fail: assert property (echo_cnt_ff == WID'(1) && rx_ff == tx_ff |=> gen_err_flag ##0 wait_idle) // RULE_15
    else $error("echo failure not flagged");
  chk_flag_clear: assert property ((gen_err_flag || crc_err_flag) ##0 s_status_read
    ##0 !crc_set |=> !gen_err_flag && !crc_err_flag) // RULE_26
    else $error("flags not cleared by status read");
endmodule : vpwed_top

// ==== testbench/tb.sv ====
// self-checking bench for the vpw error detector
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb;
  import vpwed_pkg::*;
  logic clk = '0, rst_n = '0, test_mode_in = '0, tx_drive = '0, transmitting = '0;
  logic host_tx_start = '0, xfer_start = '0, xfer_strobe = '0, xfer_long = '0, xfer_last = '0;
  logic data_xfer_active = '0, ifr_request = '0, body_crc_done = '0, body_crc_bad = '0;
  logic ifr_crc_bad = '0, reg_xchg_start = '0, reg_xchg_active = '0, reg_xchg_done = '0;
  logic test_seq_active = '0, test_fail = '0, sleep_request_bit = '0, skip_to_next_bit = '0;
  logic echo_en = '0, slow = '0, line_act = '0, abort_seen = '0;
  logic [1:0] msg_type = '0;
  logic bus_receive_input_n, bus_transmit_output, rx_seen_n, gen_err_flag, crc_err_flag;
  logic wait_idle, abort_msg, bus_quiet;
  int fail_count = 0;
  int checked = 0;
  int good[$] = '{3500, 800, 800, 800, 800, 800, 800, 800, 800};
////////////////////////////////////////
  vpwed_top #(.TV3_MAX_CYC(3800), .TV4_CYC(3800)) dut (
    .clk, .rst_n, .bus_receive_input_n, .test_mode_in, .tx_drive, .transmitting,
    .host_tx_start, .xfer_start, .xfer_strobe, .xfer_long, .xfer_last, .data_xfer_active,
    .ifr_request, .msg_type, .body_crc_done, .body_crc_bad, .ifr_crc_bad, .reg_xchg_start,
    .reg_xchg_active, .reg_xchg_done, .test_seq_active, .test_fail, .sleep_request_bit,
    .skip_to_next_bit, .bus_transmit_output, .rx_seen_n, .gen_err_flag, .crc_err_flag,
    .wait_idle, .abort_msg, .bus_quiet
  );
  vpwed_xcvr xcvr (.clk, .bus_transmit_output, .echo_en, .slow, .line_act, .bus_receive_input_n);
  always #25 clk = ~clk;
  // abort is a one-cycle pulse, so it is caught here
  always @(posedge clk)
    if (abort_msg === 1'h1)
      abort_seen <= 1'h1;
////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task sym(input logic a, input int n);
    line_act = a;
    tick(n);
  endtask : sym
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(2);
  endtask : pulse
  task res(input logic g, input logic c);
    `CHK("gen_err_flag", g, gen_err_flag)
    `CHK("crc_err_flag", c, crc_err_flag)
  endtask : res
  task clr();
    pulse(reg_xchg_done);
    res(1'h0, 1'h0);
    abort_seen = 1'h0;
  endtask : clr
  task wflag(input int n);
    repeat (n)
      if ((gen_err_flag | crc_err_flag) !== 1'h1)
        tick(1);
    if ((gen_err_flag | crc_err_flag) !== 1'h1)
    begin
      fail_count++;
      $display("mismatch error flag exp 1 got 0");
      summarize();
    end
  endtask : wflag
  task idle();
    line_act = 1'h0;
    abort_seen = 1'h0;
    repeat (9000)
      if (bus_quiet !== 1'h1)
        tick(1);
    if (bus_quiet !== 1'h1)
    begin
      fail_count++;
      $display("mismatch bus_quiet exp 1 got %h", bus_quiet);
      summarize();
    end
  endtask : idle
  // active and passive widths alternate from the start symbol
  task frame(input int w[$], input logic g, input logic c, input logic wi);
    idle();
    foreach (w[i])
      sym(i % 2 == 0, w[i]);
    sym(1'h0, 3300);
    res(g, c);
    `CHK("abort_msg", g | c, abort_seen)
    `CHK("wait_idle", wi, wait_idle)
    clr();
  endtask : frame
  task host(input int k);
    transmitting = (k < 3);
    xfer_strobe = (k == 1 || k == 2);
    xfer_last = (k == 1);
    reg_xchg_active = (k == 2);
    test_seq_active = (k == 3);
    data_xfer_active = (k == 4);
    msg_type = (k == 6) ? 2'h3 : 2'h0;
    if (k == 4)
      idle();
    tick(1);
    case (k)
      0, 1: xfer_start = 1'h1;
      2: xfer_start = 1'h1;
      3: test_fail = 1'h1;
      4: reg_xchg_start = 1'h1;
      5: {body_crc_done, body_crc_bad} = 2'h3;
      default: ifr_crc_bad = 1'h1;
    endcase
    tick(1);
    {xfer_start, test_fail, reg_xchg_start, body_crc_done, body_crc_bad, ifr_crc_bad} = '0;
    tick(2);
    res(k < 5, k > 4);
    `CHK("abort_msg", k != 4, abort_seen)
    `CHK("wait_idle", k != 4, wait_idle)
    clr();
  endtask : host
  task summarize();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
////////////////////////////////////////
  initial
  begin
    tick(20);
    rst_n = 1'h1;
    tick(2);
    res(1'h0, 1'h0);
    `CHK("wait_idle", 1'h1, wait_idle)
    // loopback is raised while the quiet indicator is still low
    test_mode_in = 1'h1;
    // passive stretch after reset must outlast the noise limit
    tick(800);
    line_act = 1'h1;
    tx_drive = 1'h1;
    tick(3);
    `CHK("bus_transmit_output", 1'h1, bus_transmit_output)
    `CHK("rx_seen_n", 1'h0, rx_seen_n)
    tick(997);
    tx_drive = 1'h0;
    tick(3);
    `CHK("rx_seen_n", 1'h1, rx_seen_n)
    res(1'h0, 1'h0);
    line_act = 1'h0;
    tick(4);
    test_mode_in = 1'h0;
    tick(800);
    echo_en = 1'h1;
    for (int k = 0; k < 2; k++)
    begin
      slow = k[0];
      tx_drive = 1'h1;
      tick(1000);
      tx_drive = 1'h0;
      tick(800);
      res(1'h0, 1'h0);
    end
    echo_en = 1'h0;
    tx_drive = 1'h1;
    wflag(260);
    res(1'h1, 1'h0);
    tx_drive = 1'h0;
    tick(300);
    clr();
    sym(1'h1, 100);
    sym(1'h0, 20);
    wflag(20);
    res(1'h1, 1'h0);
    clr();
    sleep_request_bit = 1'h1;
    sym(1'h1, 50);
    sym(1'h0, 20);
    wflag(20);
    res(1'h1, 1'h0);
    sleep_request_bit = 1'h0;
    clr();
    frame('{3500}, 1'h0, 1'h1, 1'h1);
    frame('{3500, 800, 800}, 1'h1, 1'h0, 1'h1);
    frame('{3500, 800, 3500}, 1'h1, 1'h0, 1'h1);
    frame('{2500}, 1'h1, 1'h0, 1'h1);
    frame('{4000}, 1'h0, 1'h0, 1'h1);
    msg_type = 2'h1;
    frame(good, 1'h0, 1'h0, 1'h1);
    sym(1'h1, 3500);
    sym(1'h0, 3300);
    res(1'h0, 1'h0);
    msg_type = 2'h0;
    frame(good, 1'h0, 1'h0, 1'h0);
    sym(1'h1, 3500);
    sym(1'h0, 20);
    wflag(20);
    res(1'h1, 1'h0);
    clr();
    // the quiet-bus case runs last so earlier aborts still see a recent edge
    for (int k = 0; k < 7; k++)
      host((k + 5) % 7);
    {transmitting, xfer_strobe, xfer_last, reg_xchg_active, test_seq_active, data_xfer_active} = '0;
    msg_type = 2'h0;
    ifr_request = 1'h1;
    pulse(body_crc_done);
    wflag(2800);
    res(1'h1, 1'h0);
    ifr_request = 1'h0;
    clr();
    idle();
    tick(2000);
    pulse(host_tx_start);
    res(1'h1, 1'h0);
    `CHK("abort_msg", 1'h1, abort_seen)
    clr();
    // recovery by skipping to the next frame
    skip_to_next_bit = 1'h1;
    tick(1);
    `CHK("wait_idle", 1'h1, wait_idle)
    skip_to_next_bit = 1'h0;
    tick(2);
    idle();
    tick(100);
    pulse(host_tx_start);
    res(1'h0, 1'h0);
    summarize();
  end
endmodule : tb

// ==== testbench/vpwed_xcvr.sv ====
// transceiver model: echoes the transmit pin back and injects bus symbols
`timescale 1ns/1ps
module vpwed_xcvr (
  input wire logic clk,
  input wire logic bus_transmit_output,
  input wire logic echo_en,
  input wire logic slow,
  input wire logic line_act,
  output logic bus_receive_input_n
);
  logic [39:0] lag_ff = '0;
  logic echo;
  always_ff @(posedge clk)
  begin
    lag_ff <= {lag_ff[38:0], bus_transmit_output};
  end
  // slow lag still lands well inside the echo window
  assign echo = echo_en & (slow ? lag_ff[39] : lag_ff[1]);
  // released bus is pulled to the passive level
  assign bus_receive_input_n = !(echo | line_act);
endmodule : vpwed_xcvr
